// ===== inc/ppie_evt_if.sv
// Carrier between the register bank and the event latch
`timescale 1ns/100ps
interface ppie_evt_if #(
	parameter int N = 9
);
	logic [N-1:0] enable;
	logic [N-1:0] live;
	logic [N-1:0] clear;
	logic [N-1:0] flag;
	logic         irq_req;

	modport owner (
		output enable,
		output live,
		output clear,
		input  flag,
		input  irq_req
	);

	modport latch (
		input  enable,
		input  live,
		input  clear,
		output flag,
		output irq_req
	);
endinterface

// ===== inc/ppie_pkg.sv
// Shared constants for the protection, power status and interrupt enables
package ppie_pkg;

	// ------------------------------------------------------------
	// Register port geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_PROTECT_CTRL  = 12'h013;
	localparam logic [ADDR_W-1:0] ADDR_CHAN_POWER    = 12'h014;
	localparam logic [ADDR_W-1:0] ADDR_IE_CLOCK_FIFO = 12'h01f;
	localparam logic [ADDR_W-1:0] ADDR_IE_LINK_PATH  = 12'h020;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] RST_PROTECT_CTRL = 8'h20;
	localparam logic [DATA_W-1:0] RST_IE           = 8'h00;
	localparam logic [DATA_W-1:0] READ_ZERO        = 8'h00;

	// ------------------------------------------------------------
	// Field positions of protect_and_transmit_enable_input_control
	// ------------------------------------------------------------
	localparam int BIT_SOFT_TX_VALUE    = 0;
	localparam int BIT_SOFT_TX_SEL      = 1;
	localparam int BIT_SOFT_GUARD_VALUE = 2;
	localparam int BIT_SOFT_GUARD_SEL   = 3;
	localparam int BIT_BLANKING_SEL     = 4;
	localparam int BIT_TX_GUARD_SEL     = 5;
	localparam int BIT_POWER_DETECT_SEL = 6;

	// ------------------------------------------------------------
	// Field positions of channel_power_state
	// ------------------------------------------------------------
	localparam int BIT_CHAN_A_DOWN = 5;
	localparam int BIT_CHAN_B_DOWN = 4;
	localparam int BIT_CHAN_A_UP   = 1;
	localparam int BIT_CHAN_B_UP   = 0;

	// ------------------------------------------------------------
	// Enable bit positions
	// ------------------------------------------------------------
	localparam int BIT_IE_CONV_UNLOCK   = 7;
	localparam int BIT_IE_CONV_LOCKED   = 6;
	localparam int BIT_IE_LINK_UNLOCK   = 4;
	localparam int BIT_IE_LINK_LOCKED   = 3;
	localparam int BIT_IE_LANE_ERROR    = 1;
	localparam int BIT_IE_REALIGN_ERROR = 0;
	localparam int BIT_IE_BAD_PARAM     = 7;
	localparam int BIT_IE_LANE_LEVEL    = 6;
	localparam int BIT_IE_DELAY_LEVEL   = 5;

	// ------------------------------------------------------------
	// Event indices
	// ------------------------------------------------------------
	localparam int EV_CONV_UNLOCK   = 0;
	localparam int EV_CONV_LOCKED   = 1;
	localparam int EV_LINK_UNLOCK   = 2;
	localparam int EV_LINK_LOCKED   = 3;
	localparam int EV_LANE_ERROR    = 4;
	localparam int EV_REALIGN_ERROR = 5;
	localparam int EV_BAD_PARAM     = 6;
	localparam int EV_LANE_LEVEL    = 7;
	localparam int EV_DELAY_LEVEL   = 8;
	localparam int NUM_EVENTS       = 9;

	localparam int NUM_CHAN = 2;

endpackage

// ===== src/ppie_event_latch.sv
// Per-event latch or follow logic and interrupt request
`timescale 1ns/100ps
module ppie_event_latch #(
	parameter int N = 9
) (
	input wire logic clk,
	input wire logic rst_n,
	ppie_evt_if.latch ev
);

	logic [N-1:0] flag_reg;
	logic [N-1:0] flag_next;
	logic [N-1:0] live_d_reg;
	logic [N-1:0] rise;

	// ------------------------------------------------------------
	// Per-event flag
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_ev
			assign rise[i] = ev.live[i] & ~live_d_reg[i];
			// Set beats a clear arriving in the same cycle
			assign flag_next[i] = ev.enable[i] ?
				(rise[i] | (flag_reg[i] & ~ev.clear[i])) :
				ev.live[i];
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					flag_reg[i]   <= 1'b0;
					live_d_reg[i] <= 1'b0;
				end else begin
					flag_reg[i]   <= flag_next[i];
					live_d_reg[i] <= ev.live[i];
				end
			end
		end
	endgenerate

	assign ev.flag    = flag_reg;
	// Only latched, enabled events request the interrupt
	assign ev.irq_req = |(flag_reg & ev.enable);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_latch_on_rise: assert property (
		(ev.enable & rise) != '0 |=> (flag_reg & $past(ev.enable & rise))
			== $past(ev.enable & rise))
		else $error("enabled rising event not latched");

	a_follow_live: assert property (
		1'b1 |=> ((flag_reg ^ $past(ev.live)) & ~$past(ev.enable)) == '0)
		else $error("disabled flag does not follow live state");

	a_hold_uncleared: assert property (
		1'b1 |=> ((~flag_reg) & $past(flag_reg & ev.enable & ~ev.clear))
			== '0)
		else $error("latched flag lost without clear");

	a_irq_from_flag: assert property (
		ev.irq_req == ((flag_reg & ev.enable) != '0))
		else $error("interrupt request mismatches enabled flags");

endmodule

// ===== src/ppie_regs.sv
// Protection select, channel power status and interrupt enable registers
`timescale 1ns/100ps
module ppie_regs #(
	parameter int NUM_EVENTS = ppie_pkg::NUM_EVENTS
) (
	input  wire logic                        clk,
	input  wire logic                        arst_n,
	input  wire logic [ppie_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [ppie_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [ppie_pkg::DATA_W-1:0] reg_rdata,
	output logic                             reg_rvalid,
	input  wire logic                        transmit_enable_input,
	input  wire logic                        conv_powerdown_mask,
	input  wire logic [1:0]                  chan_pd_force,
	input  wire logic [1:0]                  chan_down_ack,
	input  wire logic [1:0]                  chan_up_ack,
	input  wire logic                        power_detect_protect,
	input  wire logic                        blanking_protect,
	input  wire logic [NUM_EVENTS-1:0]       event_live,
	input  wire logic [NUM_EVENTS-1:0]       event_clear,
	output logic                             transmit_enable_out,
	output logic      [1:0]                  chan_power_down,
	output logic                             protect_out_n,
	output logic                             irq_n,
	output logic      [NUM_EVENTS-1:0]       event_flags
);

	localparam int DW    = ppie_pkg::DATA_W;
	localparam int ASYNC = NUM_EVENTS + 5;

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_s1_reg;
	logic rst_n;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// Lock detectors and analog acks run off other clocks
	logic [ASYNC-1:0] async_in;
	logic [ASYNC-1:0] sync_s1_reg;
	logic [ASYNC-1:0] sync_s2_reg;
	logic [NUM_EVENTS-1:0] live_sync;
	logic             transmit_enable_input_pin;
	logic [1:0]       down_ack_sync;
	logic [1:0]       up_ack_sync;

	assign async_in = {chan_up_ack, chan_down_ack, transmit_enable_input,
		event_live};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_s1_reg <= '0;
			sync_s2_reg <= '0;
		end else begin
			sync_s1_reg <= async_in;
			sync_s2_reg <= sync_s1_reg;
		end
	end

	assign live_sync     = sync_s2_reg[NUM_EVENTS-1:0];
	assign transmit_enable_input_pin      = sync_s2_reg[NUM_EVENTS];
	assign down_ack_sync = sync_s2_reg[NUM_EVENTS+2:NUM_EVENTS+1];
	assign up_ack_sync   = sync_s2_reg[NUM_EVENTS+4:NUM_EVENTS+3];

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	logic          hit_protect;
	logic          hit_power;
	logic          hit_ie0;
	logic          hit_ie1;
	logic [DW-1:0] protect_reg;
	logic [DW-1:0] ie0_reg;
	logic [DW-1:0] ie1_reg;
	logic [DW-1:0] power_state_reg;
	logic [DW-1:0] power_state_next;
	logic [DW-1:0] rdata_next;

	assign hit_protect = reg_addr == ppie_pkg::ADDR_PROTECT_CTRL;
	assign hit_power   = reg_addr == ppie_pkg::ADDR_CHAN_POWER;
	assign hit_ie0     = reg_addr == ppie_pkg::ADDR_IE_CLOCK_FIFO;
	assign hit_ie1     = reg_addr == ppie_pkg::ADDR_IE_LINK_PATH;

	// Status register ignores writes; unmapped reads return zero
	assign rdata_next = hit_protect ? protect_reg :
		hit_power ? power_state_reg :
		hit_ie0 ? ie0_reg :
		hit_ie1 ? ie1_reg : ppie_pkg::READ_ZERO;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			protect_reg <= ppie_pkg::RST_PROTECT_CTRL;
			ie0_reg     <= ppie_pkg::RST_IE;
			ie1_reg     <= ppie_pkg::RST_IE;
		end else if (reg_wr) begin
			if (hit_protect) protect_reg <= reg_wdata;
			if (hit_ie0) ie0_reg <= reg_wdata;
			if (hit_ie1) ie1_reg <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata  <= ppie_pkg::READ_ZERO;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) reg_rdata <= rdata_next;
		end
	end

	// ------------------------------------------------------------
	// Transmit enable and channel power
	// ------------------------------------------------------------
	logic       soft_tx_enable_sel;
	logic       soft_tx_enable_value;
	logic       transmit_enable_input_eff;
	logic [1:0] pd_req;
	logic [1:0] chan_pd_reg;

	assign soft_tx_enable_sel   = protect_reg[ppie_pkg::BIT_SOFT_TX_SEL];
	assign soft_tx_enable_value = protect_reg[ppie_pkg::BIT_SOFT_TX_VALUE];
	assign transmit_enable_input_eff = soft_tx_enable_sel ? soft_tx_enable_value :
		transmit_enable_input_pin;
	assign pd_req = chan_pd_force |
		{2{conv_powerdown_mask & ~transmit_enable_input_eff}};

	// Ack alone is not trusted: it must agree with the request
	always_comb begin
		power_state_next = ppie_pkg::READ_ZERO;
		power_state_next[ppie_pkg::BIT_CHAN_A_DOWN] =
			chan_pd_reg[0] & down_ack_sync[0];
		power_state_next[ppie_pkg::BIT_CHAN_B_DOWN] =
			chan_pd_reg[1] & down_ack_sync[1];
		power_state_next[ppie_pkg::BIT_CHAN_A_UP] =
			~chan_pd_reg[0] & up_ack_sync[0];
		power_state_next[ppie_pkg::BIT_CHAN_B_UP] =
			~chan_pd_reg[1] & up_ack_sync[1];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			transmit_enable_out <= 1'b0;
			chan_pd_reg         <= '0;
			power_state_reg     <= ppie_pkg::READ_ZERO;
		end else begin
			transmit_enable_out <= transmit_enable_input_eff;
			chan_pd_reg         <= pd_req;
			power_state_reg     <= power_state_next;
		end
	end

	assign chan_power_down = chan_pd_reg;

	// ------------------------------------------------------------
	// Protection output
	// ------------------------------------------------------------
	logic guard_fire;

	assign guard_fire =
		(protect_reg[ppie_pkg::BIT_POWER_DETECT_SEL] & power_detect_protect) |
		(protect_reg[ppie_pkg::BIT_TX_GUARD_SEL] & ~transmit_enable_input_eff) |
		(protect_reg[ppie_pkg::BIT_BLANKING_SEL] & blanking_protect) |
		(protect_reg[ppie_pkg::BIT_SOFT_GUARD_SEL] &
			protect_reg[ppie_pkg::BIT_SOFT_GUARD_VALUE]) |
		protect_reg[ppie_pkg::BIT_SOFT_GUARD_VALUE];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) protect_out_n <= 1'b1;
		else protect_out_n <= ~guard_fire;
	end

	// ------------------------------------------------------------
	// Event enables and latch
	// ------------------------------------------------------------
	ppie_evt_if #(.N(NUM_EVENTS)) ev ();

	always_comb begin
		ev.enable = '0;
		ev.enable[ppie_pkg::EV_CONV_UNLOCK] =
			ie0_reg[ppie_pkg::BIT_IE_CONV_UNLOCK];
		ev.enable[ppie_pkg::EV_CONV_LOCKED] =
			ie0_reg[ppie_pkg::BIT_IE_CONV_LOCKED];
		ev.enable[ppie_pkg::EV_LINK_UNLOCK] =
			ie0_reg[ppie_pkg::BIT_IE_LINK_UNLOCK];
		ev.enable[ppie_pkg::EV_LINK_LOCKED] =
			ie0_reg[ppie_pkg::BIT_IE_LINK_LOCKED];
		ev.enable[ppie_pkg::EV_LANE_ERROR] =
			ie0_reg[ppie_pkg::BIT_IE_LANE_ERROR];
		ev.enable[ppie_pkg::EV_REALIGN_ERROR] =
			ie0_reg[ppie_pkg::BIT_IE_REALIGN_ERROR];
		ev.enable[ppie_pkg::EV_BAD_PARAM] =
			ie1_reg[ppie_pkg::BIT_IE_BAD_PARAM];
		ev.enable[ppie_pkg::EV_LANE_LEVEL] =
			ie1_reg[ppie_pkg::BIT_IE_LANE_LEVEL];
		ev.enable[ppie_pkg::EV_DELAY_LEVEL] =
			ie1_reg[ppie_pkg::BIT_IE_DELAY_LEVEL];
	end

	assign ev.live  = live_sync;
	assign ev.clear = event_clear;

	ppie_event_latch #(.N(NUM_EVENTS)) u_latch (
		.clk   (clk),
		.rst_n (rst_n),
		.ev    (ev.latch)
	);

	assign event_flags = ev.flag;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) irq_n <= 1'b1;
		else irq_n <= ~ev.irq_req;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_write_protect;
		reg_wr && hit_protect;
	endsequence

	sequence s_soft_tx_on;
		soft_tx_enable_sel && soft_tx_enable_value;
	endsequence

	a_soft_tx_high: assert property (
		s_soft_tx_on |=> transmit_enable_out)
		else $error("software transmit enable not applied");

	a_soft_tx_low: assert property (
		soft_tx_enable_sel && !soft_tx_enable_value |=> !transmit_enable_out)
		else $error("software transmit disable not applied");

	a_pin_tx_path: assert property (
		!soft_tx_enable_sel |=> transmit_enable_out == $past(transmit_enable_input_pin))
		else $error("pin transmit enable not followed");

	a_down_status: assert property (
		power_state_reg[ppie_pkg::BIT_CHAN_A_DOWN] |->
			$past(chan_pd_reg[0] && down_ack_sync[0]))
		else $error("down status without full power down");

	a_up_status: assert property (
		power_state_reg[ppie_pkg::BIT_CHAN_B_UP] |->
			$past(!chan_pd_reg[1] && up_ack_sync[1]))
		else $error("up status without full power up");

	a_ie_write_map: assert property (
		reg_wr && hit_ie0 ##1 !(reg_wr && hit_ie0) |->
			ev.enable[ppie_pkg::EV_CONV_UNLOCK] ==
			$past(reg_wdata[ppie_pkg::BIT_IE_CONV_UNLOCK], 1))
		else $error("enable bit does not track its write");

	a_delay_enable_map: assert property (
		reg_wr && hit_ie1 |=>
			ev.enable[ppie_pkg::EV_DELAY_LEVEL] ==
			$past(reg_wdata[ppie_pkg::BIT_IE_DELAY_LEVEL]))
		else $error("delay buffer enable not written");

	a_irq_pin: assert property (
		ev.irq_req |=> !irq_n)
		else $error("interrupt output not pulled low");

	a_mask_pd: assert property (
		conv_powerdown_mask && !transmit_enable_input_eff |=> chan_power_down == 2'b11)
		else $error("masked transmit low did not power down");

	a_soft_guard: assert property (
		s_write_protect ##1
			protect_reg[ppie_pkg::BIT_SOFT_GUARD_VALUE][*2] |-> !protect_out_n)
		else $error("software guard bit did not force output low");

	a_guard_release: assert property (
		!guard_fire |=> protect_out_n)
		else $error("guard output low with no source");

	a_reset_select: assert property (
		$rose(rst_n) |-> protect_reg == ppie_pkg::RST_PROTECT_CTRL)
		else $error("protection select wrong after reset");

endmodule

// ===== test/ppie_tb.sv
// Self-checking bench for the protection and interrupt enable registers
`timescale 1ns/100ps
module testbench;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic                        clk;
	logic                        arst_n;
	logic [ppie_pkg::ADDR_W-1:0] reg_addr;
	logic [ppie_pkg::DATA_W-1:0] reg_wdata;
	logic                        reg_wr;
	logic                        reg_rd;
	logic [ppie_pkg::DATA_W-1:0] reg_rdata;
	logic                        reg_rvalid;
	logic                        tx_pin;
	logic                        pd_mask;
	logic [1:0]                  pd_force;
	logic [1:0]                  down_ack;
	logic [1:0]                  up_ack;
	logic                        pdp_src;
	logic                        blank_src;
	logic [8:0]                  ev_live;
	logic [8:0]                  ev_clear;
	logic                        transmit_enable_input_out;
	logic [1:0]                  chan_pd;
	logic                        protect_out_n;
	logic                        irq_n;
	logic [8:0]                  ev_flags;
	int                          fails;
	int                          checks_done;

	// Enable register and bit of each event, in event index order
	localparam logic [11:0] ie_addr [9] = '{12'h01f, 12'h01f, 12'h01f,
		12'h01f, 12'h01f, 12'h01f, 12'h020, 12'h020, 12'h020};
	localparam int ie_bit [9] = '{7, 6, 4, 3, 1, 0, 7, 6, 5};
	// Register value, then pdp, blanking, pin and expected level
	localparam logic [11:0] prot_tab [9] = '{{8'h00, 4'h3},
		{8'h40, 4'ha}, {8'h40, 4'h3}, {8'h10, 4'h6}, {8'h10, 4'h3},
		{8'h00, 4'hf}, {8'h20, 4'h0}, {8'h20, 4'h3}, {8'h04, 4'h2}};

	ppie_regs uut (
		.clk                   (clk),
		.arst_n                (arst_n),
		.reg_addr              (reg_addr),
		.reg_wdata             (reg_wdata),
		.reg_wr                (reg_wr),
		.reg_rd                (reg_rd),
		.reg_rdata             (reg_rdata),
		.reg_rvalid            (reg_rvalid),
		.transmit_enable_input (tx_pin),
		.conv_powerdown_mask   (pd_mask),
		.chan_pd_force         (pd_force),
		.chan_down_ack         (down_ack),
		.chan_up_ack           (up_ack),
		.power_detect_protect  (pdp_src),
		.blanking_protect      (blank_src),
		.event_live            (ev_live),
		.event_clear           (ev_clear),
		.transmit_enable_out   (transmit_enable_input_out),
		.chan_power_down       (chan_pd),
		.protect_out_n         (protect_out_n),
		.irq_n                 (irq_n),
		.event_flags           (ev_flags)
	);

	always #25 clk = ~clk;

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic stop_test;
		$display("Checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check_reg(string what, logic [7:0] exp, logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask

	task automatic check_pin(string what, logic [8:0] exp, logic [8:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask

	task automatic wait_cyc(int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wr_reg(logic [11:0] a, logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	// Answer comes exactly one cycle after the strobe, so no longer wait
	task automatic rd_expect(logic [11:0] a, logic [7:0] exp);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		check_pin("rvalid", 9'h001, {8'h00, reg_rvalid});
		check_reg($sformatf("reg %h", a), exp, reg_rdata);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		tx_pin = 1'b0;
		pd_mask = 1'b0;
		pd_force = 2'h0;
		down_ack = 2'h0;
		up_ack = 2'h0;
		pdp_src = 1'b0;
		blank_src = 1'b0;
		ev_live = 9'h000;
		ev_clear = 9'h000;
		fails = 0;
		checks_done = 0;
		wait_cyc(20);
		arst_n = 1'b1;
		wait_cyc(4);

		rd_expect(12'h013, 8'h20);
		rd_expect(12'h01f, 8'h00);
		rd_expect(12'h020, 8'h00);
		rd_expect(12'h014, 8'h00);
		check_pin("protect_n", 9'h000, {8'h00, protect_out_n});
		check_pin("transmit_enable_input", 9'h000, {8'h00, transmit_enable_input_out});
		wr_reg(12'h013, 8'ha5);
		wr_reg(12'h01f, 8'h5a);
		wr_reg(12'h020, 8'hc3);
		wr_reg(12'h014, 8'hff);
		wr_reg(12'h015, 8'hff);
		rd_expect(12'h013, 8'ha5);
		rd_expect(12'h01f, 8'h5a);
		rd_expect(12'h020, 8'hc3);
		rd_expect(12'h014, 8'h00);
		rd_expect(12'h015, 8'h00);
		wr_reg(12'h01f, 8'h00);
		wr_reg(12'h020, 8'h00);
		$display("Test registers done");

		// Software transmit enable against the pin
		wr_reg(12'h013, 8'h03);
		wait_cyc(4);
		check_pin("transmit_enable_input", 9'h001, {8'h00, transmit_enable_input_out});
		tx_pin = 1'b1;
		wr_reg(12'h013, 8'h02);
		wait_cyc(4);
		check_pin("transmit_enable_input", 9'h000, {8'h00, transmit_enable_input_out});
		wr_reg(12'h013, 8'h00);
		wait_cyc(5);
		check_pin("transmit_enable_input", 9'h001, {8'h00, transmit_enable_input_out});
		$display("Test transmit enable done");

		// Protection sources, one table row at a time
		for (int i = 0; i < 9; i++) begin
			wr_reg(12'h013, prot_tab[i][11:4]);
			pdp_src = prot_tab[i][3];
			blank_src = prot_tab[i][2];
			tx_pin = prot_tab[i][1];
			wait_cyc(6);
			check_pin("protect_n", {8'h00, prot_tab[i][0]},
				{8'h00, protect_out_n});
		end
		pdp_src = 1'b0;
		blank_src = 1'b0;
		tx_pin = 1'b1;
		$display("Test protection done");

		// Channel power requests and status
		wr_reg(12'h013, 8'h00);
		pd_mask = 1'b1;
		down_ack = 2'h3;
		up_ack = 2'h3;
		wait_cyc(6);
		check_pin("chan_pd", 9'h000, {7'h00, chan_pd});
		rd_expect(12'h014, 8'h03);
		wr_reg(12'h013, 8'h02);
		wait_cyc(6);
		check_pin("chan_pd", 9'h003, {7'h00, chan_pd});
		rd_expect(12'h014, 8'h30);
		pd_mask = 1'b0;
		pd_force = 2'h1;
		wait_cyc(6);
		rd_expect(12'h014, 8'h21);
		pd_force = 2'h2;
		wait_cyc(6);
		rd_expect(12'h014, 8'h12);
		down_ack = 2'h0;
		up_ack = 2'h0;
		wait_cyc(6);
		rd_expect(12'h014, 8'h00);
		pd_force = 2'h0;
		$display("Test power status done");

		// Each event enabled, then disabled
		for (int i = 0; i < 9; i++) begin
			wr_reg(ie_addr[i], 8'h01 << ie_bit[i]);
			ev_live = 9'h001 << i;
			wait_cyc(6);
			check_pin("flags", 9'h001 << i, ev_flags);
			check_pin("irq_n", 9'h000, {8'h00, irq_n});
			ev_live = 9'h000;
			wait_cyc(6);
			check_pin("flags", 9'h001 << i, ev_flags);
			ev_clear = 9'h001 << i;
			@(negedge clk);
			ev_clear = 9'h000;
			wait_cyc(4);
			check_pin("flags", 9'h000, ev_flags);
			check_pin("irq_n", 9'h001, {8'h00, irq_n});
			wr_reg(ie_addr[i], 8'h00);
			ev_live = 9'h001 << i;
			wait_cyc(6);
			check_pin("flags", 9'h001 << i, ev_flags);
			check_pin("irq_n", 9'h001, {8'h00, irq_n});
			ev_live = 9'h000;
			wait_cyc(6);
			check_pin("flags", 9'h000, ev_flags);
		end
		$display("Test events done");

		// Rise seen in the same cycle as a clear: set must win
		wr_reg(12'h01f, 8'h80);
		ev_live = 9'h001;
		wait_cyc(2);
		ev_clear = 9'h001;
		@(negedge clk);
		ev_clear = 9'h000;
		wait_cyc(3);
		check_pin("flags", 9'h001, ev_flags);
		check_pin("irq_n", 9'h000, {8'h00, irq_n});
		ev_live = 9'h000;
		ev_clear = 9'h001;
		@(negedge clk);
		ev_clear = 9'h000;
		wait_cyc(4);
		check_pin("flags", 9'h000, ev_flags);
		check_pin("irq_n", 9'h001, {8'h00, irq_n});
		wr_reg(12'h01f, 8'h00);
		$display("Test set over clear done");
		stop_test();
	end
endmodule
